// *** rtl/vhif_ctrl.sv ***
// Host-side control of the VBI slicer: interrupts, config RAM port, FIFO and routing.
// Assumes a byte-wide host port on sys_clk and a slicer that pushes whole lines.
//
// How it works
// R1 - Status bits stick until host writes one
// R2 - Lock change in either direction sets flag
// R3 - Status bit 7 shows live lock state
// R4 - Illegal access and finished cycles set flags
// R5 - Word count above threshold sets flag
// R6 - Programmed line in enabled field sets flag
// R7 - Sliced data available sets data flag
// R8 - Enables gate only the interrupt pin
// R9 - Pin active on status AND enable; readable
// R10 - Polarity selects open-drain low or push-pull
// R11 - Configuration bit enables YUV output pins
// R12 - Config memory is 512 bytes, 32x16
// R13 - Data port accesses then increments counter
// R14 - Two registers load 9-bit start address
// R15 - Host idles line modes before RAM access
// R16 - VBI flags write-one clear; empty live
// R17 - Line too big dropped whole, error set
// R18 - Word count reports occupancy in words
// R19 - Any write to flush register empties FIFO
// R20 - Switch pixel position, resets to 0x1E
// R21 - Route FIFO to video or host port
// R22 - Full field slices lines with full standard
// R23 - Set beats write-one clear same cycle
`timescale 1ns/100ps
`include "vhif_cfg.svh"

module vhif_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host port register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic host_port_err,
  output logic [7:0] reg_rdata,
  output logic reg_done,
  // Decoder timing and status
  input wire logic video_lock,
  input wire logic line_strobe,
  input wire logic [9:0] line_num,
  input wire logic field_two,
  input wire logic [9:0] pixel_cnt,
  input wire logic in_vblank,
  input wire logic [7:0] line_mode,
  input wire logic [7:0] full_field_std,
  // Slicer data events and line stream
  input wire vhif_pkg::vhif_avail_t vbi_avail,
  input wire logic line_start,
  input wire logic [8:0] line_bytes,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Slicer reads of the config memory
  input wire logic [8:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data,
  // FIFO output toward video port
  input wire logic yout_ready,
  output logic [7:0] yout_data,
  output logic yout_valid,
  // Pins and slicer controls
  output logic irq_out,
  output logic irq_oe,
  output logic yuv_output_enable,
  output logic switch_strobe,
  output logic [7:0] slice_mode,
  output logic host_access,
  output logic [1:0] auto_setup
);

  localparam vhif_pkg::vhif_state_t ST_RST = '{
    yuv_en: 1'b1,
    threshold: `VHIF_RST_THRESHOLD,
    swpix: `VHIF_RST_SWPIX,
    line_irq: `VHIF_RST_LINE_IRQ,
    wr_state: vhif_pkg::WR_IDLE,
    default: '0
  };

  vhif_pkg::vhif_state_t s_ff;
  vhif_pkg::vhif_state_t nxt_s;

  // Memories: slicer configuration slots and the VBI byte FIFO
  logic [7:0] cfg_mem [`VHIF_CFG_RAM_BYTES];
  logic [7:0] fifo_mem [`VHIF_CFG_RAM_BYTES];

  logic [7:0] int_set, int_clr, vbi_set, vbi_clr, word_cnt;
  logic [9:0] fifo_free;
  logic above, bad_access, pop_vid, pop_host, push, line_done, too_big, flush;
  logic ram_wr, ram_step, fifo_empty;

  // Strobe qualified by address; used by every decode except the read data mux
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // Occupancy in words, saturating where the byte count outgrows the field
  always_comb begin
    fifo_empty = (s_ff.count == 10'h000);
    fifo_free = `VHIF_FIFO_BYTES - s_ff.count;
    if (s_ff.count >= `VHIF_WORDS_SATURATE) begin
      word_cnt = 8'hff;
    end else begin
      word_cnt = s_ff.count[8:1]; // [R18]
    end
    above = word_cnt > s_ff.threshold;
  end

  // Access checks, FIFO movement and line admission
  always_comb begin
    flush = hit(reg_wr, reg_addr, `VHIF_OFS_FLUSH); // [R19]
    bad_access = hit(reg_wr, reg_addr, `VHIF_OFS_WORD_CNT)
      || hit(reg_wr, reg_addr, `VHIF_OFS_FIFO_READ)
      || (hit(reg_rd, reg_addr, `VHIF_OFS_FIFO_READ) && (!s_ff.host_acc || fifo_empty));
    // Video drain only when host access is off [R21]
    pop_vid = !s_ff.host_acc && !fifo_empty && (!s_ff.yout_valid || yout_ready);
    pop_host = s_ff.host_acc && !fifo_empty && hit(reg_rd, reg_addr, `VHIF_OFS_FIFO_READ);
    push = (s_ff.wr_state == vhif_pkg::WR_LOAD) && byte_valid;
    line_done = push && (s_ff.wr_left == 9'h001);
    // A line is admitted only when all of it fits [R17]
    too_big = {1'b0, line_bytes} > fifo_free;
    ram_wr = hit(reg_wr, reg_addr, `VHIF_OFS_RAM_DATA);
    ram_step = ram_wr || hit(reg_rd, reg_addr, `VHIF_OFS_RAM_DATA);
  end

  // Sticky flag sources
  always_comb begin
    int_set = 8'h00;
    int_set[`VHIF_IS_LOCK_CHG] = video_lock != s_ff.lock_q; // [R2]
    int_set[`VHIF_IS_CYCLE] = reg_wr || reg_rd; // [R4]
    int_set[`VHIF_IS_BUS_ERR] = host_port_err || bad_access; // [R4]
    int_set[`VHIF_IS_THRESHOLD] = above && !s_ff.above_q; // [R5]
    // Lines 0 and 1 never match; each field has its own enable [R6]
    int_set[`VHIF_IS_LINE] = line_strobe
      && (line_num == {4'h0, s_ff.line_irq[5:0]})
      && (s_ff.line_irq[5:0] >= `VHIF_LI_MIN_LINE)
      && (field_two ? s_ff.line_irq[`VHIF_LI_FIELD2] : s_ff.line_irq[`VHIF_LI_FIELD1]);
    int_set[`VHIF_IS_DATA] = (|vbi_avail) || line_done; // [R7]
    int_clr = hit(reg_wr, reg_addr, `VHIF_OFS_INT_STAT) ? reg_wdata : 8'h00;
    vbi_set = {1'b0, 1'b0, vbi_avail};
    vbi_set[`VHIF_VS_FULL_ERR] = (s_ff.wr_state == vhif_pkg::WR_IDLE) && line_start && too_big;
    vbi_clr = hit(reg_wr, reg_addr, `VHIF_OFS_VBI_STAT) ? reg_wdata : 8'h00;
  end

  // Next state of the whole block
  always_comb begin
    nxt_s = s_ff;
    nxt_s.lock_q = video_lock;
    nxt_s.above_q = above;
    // Set wins over a write-one clear in the same cycle [R1] [R23]
    nxt_s.int_stat = ((s_ff.int_stat & ~int_clr) | int_set) & `VHIF_IS_STORED;
    // Reads never clear; empty is not stored but read live [R16] [R23]
    nxt_s.vbi_stat = ((s_ff.vbi_stat & ~vbi_clr) | vbi_set) & `VHIF_VS_STICKY;

    // Control registers written by the host
    if (hit(reg_wr, reg_addr, `VHIF_OFS_INT_EN)) begin
      nxt_s.int_en = reg_wdata & `VHIF_IS_STORED;
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_INT_CFG)) begin
      nxt_s.polarity = reg_wdata[`VHIF_IC_POLARITY];
      nxt_s.yuv_en = reg_wdata[`VHIF_IC_YUV_EN]; // [R11]
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_THRESHOLD)) begin
      nxt_s.threshold = reg_wdata;
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_LINE_IRQ)) begin
      nxt_s.line_irq = reg_wdata;
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_SWPIX_LO)) begin
      nxt_s.swpix[7:0] = reg_wdata; // [R20]
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_SWPIX_HI)) begin
      nxt_s.swpix[9:8] = reg_wdata[1:0]; // [R20]
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_ROUTE)) begin
      nxt_s.host_acc = reg_wdata[0]; // [R21]
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_AUTO_SETUP)) begin
      nxt_s.auto_setup = reg_wdata[2:1];
    end
    if (hit(reg_wr, reg_addr, `VHIF_OFS_FULL_FIELD)) begin
      nxt_s.full_field = reg_wdata[0];
    end

    // Config memory address counter; a data access steps it by one [R13] [R14]
    if (hit(reg_wr, reg_addr, `VHIF_OFS_RAM_ADDR_LO)) begin
      nxt_s.ram_addr[7:0] = reg_wdata;
    end else if (hit(reg_wr, reg_addr, `VHIF_OFS_RAM_ADDR_HI)) begin
      nxt_s.ram_addr[8] = reg_wdata[0];
    end else if (ram_step) begin
      nxt_s.ram_addr = s_ff.ram_addr + 9'h001;
    end
    nxt_s.cfg_rdata = cfg_mem[cfg_rd_addr];

    // Interrupt pin: enables gate only the pin, never the flags [R8] [R9]
    nxt_s.irq_active = |(nxt_s.int_stat & nxt_s.int_en);
    // Active low is open drain; active high drives both levels [R10]
    nxt_s.irq_out = nxt_s.polarity && nxt_s.irq_active;
    nxt_s.irq_oe = nxt_s.polarity || nxt_s.irq_active;

    // Whole-line loader; a dropped line is still counted off byte by byte [R17]
    case (s_ff.wr_state)
      vhif_pkg::WR_IDLE: begin
        if (line_start && (line_bytes != 9'h000)) begin
          nxt_s.wr_left = line_bytes;
          nxt_s.wr_state = too_big ? vhif_pkg::WR_DROP : vhif_pkg::WR_LOAD;
        end
      end
      default: begin
        if (byte_valid) begin
          nxt_s.wr_left = s_ff.wr_left - 9'h001;
          if (s_ff.wr_left == 9'h001) begin
            nxt_s.wr_state = vhif_pkg::WR_IDLE;
          end
        end
      end
    endcase

    // FIFO pointers and output toward the video port
    if (push) begin
      nxt_s.wr_ptr = s_ff.wr_ptr + 9'h001;
    end
    if (pop_vid || pop_host) begin
      nxt_s.rd_ptr = s_ff.rd_ptr + 9'h001;
    end
    nxt_s.count = s_ff.count + {9'h000, push} - {9'h000, pop_vid || pop_host};
    if (pop_vid) begin
      nxt_s.yout_valid = 1'b1;
      nxt_s.yout_data = fifo_mem[s_ff.rd_ptr];
    end else if (yout_ready) begin
      nxt_s.yout_valid = 1'b0;
    end
    // Flush discards stored bytes and any line still arriving [R19]
    if (flush) begin
      nxt_s.wr_ptr = 9'h000;
      nxt_s.rd_ptr = 9'h000;
      nxt_s.count = 10'h000;
      nxt_s.yout_valid = 1'b0;
      if (s_ff.wr_state == vhif_pkg::WR_LOAD) begin
        nxt_s.wr_state = vhif_pkg::WR_DROP;
      end
    end

    // Full field applies outside blanking and on lines left at the full code [R22]
    if (s_ff.full_field && (!in_vblank || (line_mode == `VHIF_LINE_MODE_FULL))) begin
      nxt_s.slice_mode = full_field_std;
    end else begin
      nxt_s.slice_mode = line_mode;
    end
    nxt_s.sw_strobe = pixel_cnt == s_ff.swpix; // [R20]

    // Read data, registered one cycle after the strobe
    nxt_s.done = reg_wr || reg_rd;
    if (reg_rd) begin
      if (reg_addr == `VHIF_OFS_FIFO_READ) begin
        nxt_s.rdata = pop_host ? fifo_mem[s_ff.rd_ptr] : 8'h00;
      end else if (reg_addr == `VHIF_OFS_INT_STAT) begin
        nxt_s.rdata = {s_ff.lock_q, s_ff.int_stat[6:0]}; // [R3]
      end else if (reg_addr == `VHIF_OFS_INT_EN) begin
        nxt_s.rdata = s_ff.int_en;
      end else if (reg_addr == `VHIF_OFS_INT_CFG) begin
        nxt_s.rdata = {5'h00, s_ff.yuv_en, s_ff.irq_active, s_ff.polarity}; // [R9]
      end else if (reg_addr == `VHIF_OFS_RAM_DATA) begin
        nxt_s.rdata = cfg_mem[s_ff.ram_addr]; // [R13]
      end else if (reg_addr == `VHIF_OFS_RAM_ADDR_LO) begin
        nxt_s.rdata = s_ff.ram_addr[7:0];
      end else if (reg_addr == `VHIF_OFS_RAM_ADDR_HI) begin
        nxt_s.rdata = {7'h00, s_ff.ram_addr[8]};
      end else if (reg_addr == `VHIF_OFS_VBI_STAT) begin
        nxt_s.rdata = {s_ff.vbi_stat[7], fifo_empty, s_ff.vbi_stat[5:0]}; // [R16]
      end else if (reg_addr == `VHIF_OFS_WORD_CNT) begin
        nxt_s.rdata = word_cnt; // [R18]
      end else if (reg_addr == `VHIF_OFS_THRESHOLD) begin
        nxt_s.rdata = s_ff.threshold;
      end else if (reg_addr == `VHIF_OFS_LINE_IRQ) begin
        nxt_s.rdata = s_ff.line_irq;
      end else if (reg_addr == `VHIF_OFS_SWPIX_LO) begin
        nxt_s.rdata = s_ff.swpix[7:0];
      end else if (reg_addr == `VHIF_OFS_SWPIX_HI) begin
        nxt_s.rdata = {6'h00, s_ff.swpix[9:8]};
      end else if (reg_addr == `VHIF_OFS_ROUTE) begin
        nxt_s.rdata = {7'h00, s_ff.host_acc};
      end else if (reg_addr == `VHIF_OFS_AUTO_SETUP) begin
        nxt_s.rdata = {5'h00, s_ff.auto_setup, 1'b0};
      end else if (reg_addr == `VHIF_OFS_FULL_FIELD) begin
        nxt_s.rdata = {7'h00, s_ff.full_field};
      end else begin
        nxt_s.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Memory writes; contents have no reset, software loads the slots [R12]
  always_ff @(posedge sys_clk) begin
    if (ram_wr) begin
      cfg_mem[s_ff.ram_addr] <= reg_wdata; // [R13]
    end
    if (push) begin
      fifo_mem[s_ff.wr_ptr] <= byte_data;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s_ff.rdata;
  assign reg_done = s_ff.done;
  assign cfg_rd_data = s_ff.cfg_rdata;
  assign yout_data = s_ff.yout_data;
  assign yout_valid = s_ff.yout_valid;
  assign irq_out = s_ff.irq_out;
  assign irq_oe = s_ff.irq_oe;
  assign yuv_output_enable = s_ff.yuv_en;
  assign switch_strobe = s_ff.sw_strobe;
  assign slice_mode = s_ff.slice_mode;
  assign host_access = s_ff.host_acc;
  assign auto_setup = s_ff.auto_setup;

  // Checks on the block's own behaviour
  property p_w1c_clear; // [R1]
    @(posedge sys_clk) disable iff (!rst_n)
    hit(reg_wr, reg_addr, `VHIF_OFS_INT_STAT) && reg_wdata[0] && !int_set[0]
      |=> !s_ff.int_stat[0];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("data flag not cleared by write one");
  property p_set_wins; // [R23]
    @(posedge sys_clk) disable iff (!rst_n)
    hit(reg_wr, reg_addr, `VHIF_OFS_INT_STAT) && reg_wdata[6] && (video_lock != s_ff.lock_q)
      |=> s_ff.int_stat[6];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("lock change lost to clear");
  property p_lock_read; // [R3]
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && (reg_addr == `VHIF_OFS_INT_STAT) |=> reg_rdata[7] == $past(video_lock, 2);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock state bit wrong");
  property p_pin_low_mode; // [R10]
    @(posedge sys_clk) disable iff (!rst_n)
    !s_ff.polarity |-> !irq_out && (irq_oe == s_ff.irq_active);
  endproperty
  a_pin_low_mode: assert property (p_pin_low_mode) else $error("open drain pin misdriven");
  property p_mask_gate; // [R8]
    @(posedge sys_clk) disable iff (!rst_n)
    (s_ff.int_en == 8'h00) && (int_set[`VHIF_IS_CYCLE]) |=> s_ff.int_stat[5] && !s_ff.irq_active
      || (s_ff.int_en != 8'h00);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("enable gated flag or pin wrong");
  property p_flush; // [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    hit(reg_wr, reg_addr, `VHIF_OFS_FLUSH) |=> (s_ff.count == 10'h000) && !yout_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left data");
  property p_ram_step; // [R13]
    @(posedge sys_clk) disable iff (!rst_n)
    hit(reg_wr, reg_addr, `VHIF_OFS_RAM_DATA) |=> s_ff.ram_addr == $past(s_ff.ram_addr) + 9'h001;
  endproperty
  a_ram_step: assert property (p_ram_step) else $error("ram counter did not step");
  property p_reject; // [R17]
    @(posedge sys_clk) disable iff (!rst_n)
    (s_ff.wr_state == vhif_pkg::WR_IDLE) && line_start && too_big && (line_bytes != 9'h000)
      |=> s_ff.vbi_stat[7] && (s_ff.wr_state == vhif_pkg::WR_DROP) ##1 !push;
  endproperty
  a_reject: assert property (p_reject) else $error("oversized line not dropped");

  property p_threshold; // [R5]
    @(posedge sys_clk) disable iff (!rst_n)
    above && !s_ff.above_q |=> s_ff.int_stat[`VHIF_IS_THRESHOLD];
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold flag missed");

  property p_route; // [R21]
    @(posedge sys_clk) disable iff (!rst_n)
    s_ff.host_acc && !yout_valid |=> !yout_valid;
  endproperty
  a_route: assert property (p_route) else $error("video output ran in host mode");

  property p_switch; // [R20]
    @(posedge sys_clk) disable iff (!rst_n)
    (pixel_cnt == s_ff.swpix) |=> switch_strobe;
  endproperty
  a_switch: assert property (p_switch) else $error("switch strobe missed");

endmodule

// *** rtl/vhif_cfg.svh ***
// Offsets, field positions, reset values and sizes of the VBI host interrupt/FIFO block.
// Assumes byte-wide registers on the internal host port, one byte per offset.
`ifndef VHIF_CFG_SVH
`define VHIF_CFG_SVH

// Register offsets on the host port
`define VHIF_OFS_FIFO_READ 8'hb0
`define VHIF_OFS_INT_STAT 8'hc0
`define VHIF_OFS_INT_EN 8'hc1
`define VHIF_OFS_INT_CFG 8'hc2
`define VHIF_OFS_RAM_DATA 8'hc3
`define VHIF_OFS_RAM_ADDR_LO 8'hc4
`define VHIF_OFS_RAM_ADDR_HI 8'hc5
`define VHIF_OFS_VBI_STAT 8'hc6
`define VHIF_OFS_WORD_CNT 8'hc7
`define VHIF_OFS_THRESHOLD 8'hc8
`define VHIF_OFS_FLUSH 8'hc9
`define VHIF_OFS_LINE_IRQ 8'hca
`define VHIF_OFS_SWPIX_LO 8'hcb
`define VHIF_OFS_SWPIX_HI 8'hcc
`define VHIF_OFS_ROUTE 8'hcd
`define VHIF_OFS_AUTO_SETUP 8'hce
`define VHIF_OFS_FULL_FIELD 8'hcf

// Interrupt status bit positions
`define VHIF_IS_LOCK_STATE 7
`define VHIF_IS_LOCK_CHG 6
`define VHIF_IS_CYCLE 5
`define VHIF_IS_BUS_ERR 4
`define VHIF_IS_THRESHOLD 2
`define VHIF_IS_LINE 1
`define VHIF_IS_DATA 0
// Bits that hardware stores; bit 7 is live and bit 3 reserved
`define VHIF_IS_STORED 8'h77

// VBI status bit positions
`define VHIF_VS_FULL_ERR 7
`define VHIF_VS_EMPTY 6
// Bits that only a write of one clears
`define VHIF_VS_STICKY 8'hbf

// Interrupt configuration bit positions
`define VHIF_IC_YUV_EN 2
`define VHIF_IC_ACTIVE 1
`define VHIF_IC_POLARITY 0

// Line interrupt register fields
`define VHIF_LI_FIELD1 7
`define VHIF_LI_FIELD2 6
`define VHIF_LI_MIN_LINE 6'h02

// Reset values
`define VHIF_RST_THRESHOLD 8'h80
`define VHIF_RST_SWPIX 10'h01e
`define VHIF_RST_LINE_IRQ 8'h00

// Memory sizes in bytes and the full-field line mode code
`define VHIF_CFG_RAM_BYTES 512
`define VHIF_FIFO_BYTES 10'h200
`define VHIF_WORDS_SATURATE 10'h1fe
`define VHIF_LINE_MODE_FULL 8'hff

`endif

// *** rtl/vhif_pkg.sv ***
// Types for the VBI host interrupt/FIFO block.
// Assumes the constants header is included by the design that uses these types.
package vhif_pkg;

  // Line loader state for writing whole sliced lines into the FIFO
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_LOAD,
    WR_DROP
  } vhif_wr_state_t;

  // One-cycle data-available events from the slicer
  typedef struct packed {
    logic teletext_data;
    logic cc_field1;
    logic cc_field2;
    logic wss;
    logic vps;
    logic vitc;
  } vhif_avail_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] int_stat;
    logic [7:0] int_en;
    logic polarity;
    logic yuv_en;
    logic irq_active;
    logic irq_out;
    logic irq_oe;
    logic [8:0] ram_addr;
    logic [7:0] vbi_stat;
    logic [7:0] threshold;
    logic above_q;
    logic [7:0] line_irq;
    logic [9:0] swpix;
    logic sw_strobe;
    logic host_acc;
    logic [1:0] auto_setup;
    logic full_field;
    logic [7:0] slice_mode;
    logic lock_q;
    logic [8:0] wr_ptr;
    logic [8:0] rd_ptr;
    logic [9:0] count;
    vhif_wr_state_t wr_state;
    logic [8:0] wr_left;
    logic [7:0] rdata;
    logic done;
    logic [7:0] yout_data;
    logic yout_valid;
    logic [7:0] cfg_rdata;
  } vhif_state_t;

endpackage

// *** bench/vhif_host_model.sv ***
// Host processor model driving the register port of the VBI control block.
// Assumes single-cycle strobes on sys_clk and an answer exactly one cycle later.
`timescale 1ns/100ps
module vhif_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port toward the block
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_done
);
  // Idle port until the first access
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One access; on release strobes drop and address and data are inverted so a stale value never looks valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] rdata, output logic done);
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
    rdata = reg_rdata;
    done = reg_done;
  endtask
endmodule

// *** bench/vbi_host_interrupt_fifo_ctrl_tb_top.sv ***
// Self-checking bench for the VBI host interrupt and FIFO control block.
// Assumes the host model answers through a hierarchical task call.
`timescale 1ns/100ps
`include "vhif_cfg.svh"
module vbi_host_interrupt_fifo_ctrl_tb_top;
  typedef struct packed {logic [7:0] addr; logic [7:0] exp;} vhif_row_t;
  logic sys_clk, rst_n, reg_wr, reg_rd, host_port_err, reg_done, video_lock, line_strobe;
  logic field_two, line_start, byte_valid, yout_ready, yout_valid, irq_out, irq_oe;
  logic yuv_output_enable, done_val, switch_strobe, in_vblank, host_access;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, byte_data, cfg_rd_data, yout_data, rd_val;
  logic [7:0] line_mode, full_field_std, slice_mode;
  logic [9:0] line_num, pixel_cnt;
  logic [8:0] line_bytes, cfg_rd_addr;
  vhif_pkg::vhif_avail_t vbi_avail;
  int error_cnt = 0;
  int comparisons = 0;
  vhif_row_t rows [8] = '{'{8'hc1, 8'h00}, '{8'hc2, 8'h04}, '{8'hc6, 8'h40},
    '{8'hc7, 8'h00}, '{8'hc8, 8'h80}, '{8'hca, 8'h00}, '{8'hcb, 8'h1e}, '{8'hd0, 8'h00}};

  vhif_ctrl vhif_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .host_port_err(host_port_err), .reg_rdata(reg_rdata), .reg_done(reg_done),
    .video_lock(video_lock), .line_strobe(line_strobe), .line_num(line_num),
    .field_two(field_two), .pixel_cnt(pixel_cnt), .in_vblank(in_vblank),
    .line_mode(line_mode), .full_field_std(full_field_std),
    .vbi_avail(vbi_avail), .line_start(line_start), .line_bytes(line_bytes),
    .byte_valid(byte_valid), .byte_data(byte_data), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_data(cfg_rd_data), .yout_ready(yout_ready), .yout_data(yout_data),
    .yout_valid(yout_valid), .irq_out(irq_out), .irq_oe(irq_oe),
    .yuv_output_enable(yuv_output_enable), .switch_strobe(switch_strobe),
    .slice_mode(slice_mode), .host_access(host_access), .auto_setup());
  vhif_host_model vhif_host_model_inst (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_done(reg_done));

  // Clock at 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    vhif_host_model_inst.access(1'b1, a, d, rd_val, done_val);
  endtask

  task automatic rd(input logic [7:0] a);
    vhif_host_model_inst.access(1'b0, a, 8'h00, rd_val, done_val);
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Whole line: start pulse, then one byte per cycle
  task automatic send_line(input int n);
    @(posedge sys_clk);
    line_start <= 1'b1;
    line_bytes <= n[8:0];
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      line_start <= 1'b0;
      byte_valid <= 1'b1;
      byte_data <= i[7:0];
    end
    @(posedge sys_clk);
    byte_valid <= 1'b0;
    clk(2);
  endtask

  task automatic line_pulse(input logic f2);
    @(posedge sys_clk);
    line_strobe <= 1'b1;
    field_two <= f2;
    line_num <= 10'h005;
    @(posedge sys_clk);
    line_strobe <= 1'b0;
  endtask

  // Watchdog sized well above the expected run of about 1400 cycles
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    {rst_n, host_port_err, video_lock, line_strobe, field_two} = '0;
    {line_start, byte_valid, yout_ready, in_vblank} = '0;
    {line_num, pixel_cnt, line_bytes, byte_data, cfg_rd_addr, vbi_avail, full_field_std} = '0;
    line_mode = 8'hff; // Line modes idle so config RAM access is legal
    clk(12);
    rst_n <= 1'b1;
    // Reset values and unmapped read
    foreach (rows[i]) begin
      rd(rows[i].addr);
      chk("reg", rd_val, rows[i].exp);
      chk("done", {7'h00, done_val}, 8'h01);
    end
    rd(8'hc0);
    chk("cycle", rd_val, 8'h20);
    // Lock change both ways, live lock bit, write-one clear
    video_lock <= 1'b1;
    rd(8'hc0);
    chk("lock_on", rd_val, 8'he0);
    wr(8'hc0, 8'h40);
    rd(8'hc0);
    chk("lock_clr", rd_val, 8'ha0);
    video_lock <= 1'b0;
    rd(8'hc0);
    chk("lock_off", rd_val, 8'h60);
    wr(8'hc0, 8'h40);
    // Lock change and its clear in one cycle: the change survives
    fork
      wr(8'hc0, 8'h40);
      @(posedge sys_clk) video_lock <= 1'b1;
    join
    rd(8'hc0);
    chk("set_wins", rd_val & 8'h40, 8'h40);
    video_lock <= 1'b0;
    wr(8'hc0, 8'h40);
    host_port_err <= 1'b1;
    @(posedge sys_clk) host_port_err <= 1'b0;
    rd(8'hc0);
    chk("bus_err", rd_val, 8'h30);
    wr(8'hc0, 8'h10);
    // Pin: cycle flag enabled, both polarities, then masked, then YUV off
    wr(8'hc1, 8'h20);
    clk(2);
    chk("pin_low", {6'h00, irq_oe, irq_out}, 8'h02);
    rd(8'hc2);
    chk("cfg_act", rd_val, 8'h06);
    wr(8'hc2, 8'h05);
    clk(2);
    chk("pin_high", {6'h00, irq_oe, irq_out}, 8'h03);
    wr(8'hc1, 8'h00);
    clk(2);
    chk("pin_mask", {6'h00, irq_oe, irq_out}, 8'h02);
    wr(8'hc2, 8'h00);
    clk(2);
    chk("pin_off", {5'h00, yuv_output_enable, irq_oe, irq_out}, 8'h00);
    // Line match only in enabled field
    wr(8'hca, 8'h85);
    line_pulse(1'b1);
    rd(8'hc0);
    chk("line_f2", rd_val & 8'h02, 8'h00);
    line_pulse(1'b0);
    rd(8'hc0);
    chk("line_f1", rd_val & 8'h02, 8'h02);
    // Data flag and sticky VBI status
    @(posedge sys_clk) vbi_avail.teletext_data <= 1'b1;
    @(posedge sys_clk) vbi_avail.teletext_data <= 1'b0;
    rd(8'hc0);
    chk("data", rd_val & 8'h01, 8'h01);
    rd(8'hc6);
    rd(8'hc6);
    chk("vbi_stick", rd_val, 8'h60);
    wr(8'hc6, 8'h20);
    rd(8'hc6);
    chk("vbi_clr", rd_val, 8'h40);
    // Config RAM: load address 110h, write three, reload, read back
    wr(8'hc4, 8'h10);
    wr(8'hc5, 8'h01);
    for (int i = 0; i < 3; i++) wr(8'hc3, 8'haa + 8'(i * 17));
    wr(8'hc4, 8'h10);
    wr(8'hc5, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd(8'hc3);
      chk("ram", rd_val, 8'haa + 8'(i * 17));
    end
    cfg_rd_addr <= 9'h111;
    clk(3);
    chk("ram_slicer", cfg_rd_data, 8'hbb);
    // Switch strobe on the full 10-bit pixel match only
    pixel_cnt <= 10'h01e;
    clk(2);
    chk("switch", {7'h00, switch_strobe}, 8'h01);
    pixel_cnt <= 10'h21e;
    clk(2);
    chk("switch_hi", {7'h00, switch_strobe}, 8'h00);
    // Full field standard outside blanking, per-line mode inside it
    full_field_std <= 8'h31;
    wr(8'hcf, 8'h01);
    clk(1);
    chk("ff_std", slice_mode, 8'h31);
    in_vblank <= 1'b1;
    line_mode <= 8'h05;
    clk(2);
    chk("ff_line", slice_mode, 8'h05);
    // FIFO held for host port, counted, flushed
    wr(8'hcd, 8'h01);
    send_line(4);
    chk("no_video", {6'h00, host_access, yout_valid}, 8'h02);
    rd(8'hc7);
    chk("words", rd_val, 8'h02);
    wr(8'hc9, 8'h5a);
    rd(8'hc7);
    chk("flushed", rd_val, 8'h00);
    // Fill past threshold, drop an oversized line, then accept a fitting one
    wr(8'hc8, 8'h10);
    send_line(500);
    rd(8'hc0);
    chk("thresh", rd_val & 8'h04, 8'h04);
    send_line(20);
    rd(8'hc7);
    chk("drop_cnt", rd_val, 8'hfa);
    rd(8'hc6);
    chk("full_err", rd_val & 8'h80, 8'h80);
    send_line(12);
    rd(8'hc7);
    chk("sat", rd_val, 8'hff);
    // Route to video with the far side stalled, then drain
    wr(8'hcd, 8'h00);
    clk(3);
    chk("video", {yout_valid, yout_data[6:0]}, 8'h80);
    yout_ready <= 1'b1;
    clk(600);
    rd(8'hc6);
    chk("empty", rd_val & 8'h40, 8'h40);
    // Reset in mid-run restores defaults
    rst_n <= 1'b0;
    clk(2);
    rst_n <= 1'b1;
    rd(8'hc8);
    chk("rst_thr", rd_val, 8'h80);
    print_verdict();
  end
endmodule
